// >>> shared/swdt_regs.svh
// timing constants and field values for the system watchdog
// assumes sys_clk at 100 MHz; included by bare name
`ifndef SWDT_REGS_SVH
`define SWDT_REGS_SVH
`define SWDT_CLK_HZ        100000000
`define SWDT_SEC_PER_MIN   60
`define SWDT_TICK_W        8
`define SWDT_TICK_MIN      8'h01
`define SWDT_TICK_MAX      8'hFF
`define SWDT_TICK_RST      8'hFF
`define SWDT_UNIT_SEC      1'b0
`define SWDT_UNIT_MIN      1'b1
`define SWDT_RST_PULSE     16
`endif

// >>> shared/swdt_pkg.sv
// types for the system watchdog
// assumes nothing beyond a SystemVerilog compiler
package swdt_pkg;
  typedef enum logic [2:0] {
    SWDT_OP_NONE  = 3'b000,
    SWDT_OP_INIT  = 3'b001,
    SWDT_OP_SET   = 3'b010,
    SWDT_OP_START = 3'b011,
    SWDT_OP_KICK  = 3'b100,
    SWDT_OP_STOP  = 3'b101
  } swdt_op_type;
  typedef enum logic [1:0] {
    SWDT_ST_UNINIT  = 2'b00,
    SWDT_ST_STOPPED = 2'b01,
    SWDT_ST_RUNNING = 2'b10,
    SWDT_ST_FIRING  = 2'b11
  } swdt_state_type;
endpackage : swdt_pkg

// >>> rtl/swdt_prescaler.sv
// time base: one-cycle pulse per second and per minute
// assumes clk_en gates all state; clear restarts both phases
module swdt_prescaler #(
  parameter int unsigned SEC_CYCLES = 100000000,
  parameter int unsigned SEC_PER_MIN = 60
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic clear,
  output logic      sec_tick,
  output logic      min_tick
);
  logic [31:0] cyc_r;
  logic [7:0]  sec_r;

  always_ff @(posedge sys_clk) begin
    if (rst || (clk_en && clear)) begin
      cyc_r    <= 32'h0;
      sec_r    <= 8'h0;
      sec_tick <= 1'b0;
      min_tick <= 1'b0;
    end else if (clk_en) begin
      sec_tick <= 1'b0;
      min_tick <= 1'b0;
      if (cyc_r == 32'(SEC_CYCLES - 1)) begin
        cyc_r    <= 32'h0;
        sec_tick <= 1'b1;
        if (sec_r == 8'(SEC_PER_MIN - 1)) begin
          sec_r    <= 8'h0;
          min_tick <= 1'b1;
        end else begin
          sec_r <= sec_r + 8'h01;
        end
      end else begin
        cyc_r <= cyc_r + 32'h1;
      end
    end
  end
endmodule : swdt_prescaler

// >>> rtl/swdt_core.sv
// system watchdog: operation port, countdown and system reset output
// assumes op_valid comes from logic on sys_clk; no synchroniser needed
// Summary of operation
// - timeout tick count is one to 255; zero is invalid
// - unit zero makes each tick one second long
// - unit one makes each tick one minute long
// - start begins the countdown from the programmed timeout at once
// - countdown expiry asserts the whole-system reset output
// - kick reloads the countdown with the last programmed timeout
// - stop halts counting; no expiry until started again
// - every operation reports success or failure
`include "swdt_regs.svh"
module swdt_core #(
  parameter int unsigned SEC_CYCLES  = `SWDT_CLK_HZ,
  parameter int unsigned RST_CYCLES  = `SWDT_RST_PULSE
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  input  wire logic                    op_valid,
  input  wire swdt_pkg::swdt_op_type   op_code,
  input  wire logic [`SWDT_TICK_W-1:0] op_tick,
  input  wire logic                    op_unit,
  output logic                         op_done_r,
  output logic                         op_ok_r,
  output logic                         running_r,
  output logic                         sys_reset_r
);
  swdt_pkg::swdt_state_type    state_r;
  swdt_pkg::swdt_state_type    state_nxt;
  logic [`SWDT_TICK_W-1:0]     tick_cfg_r;
  logic                        unit_cfg_r;
  logic [`SWDT_TICK_W-1:0]     count_r;
  logic [15:0]                 fire_r;
  logic                        sec_tick;
  logic                        min_tick;
  logic                        unit_tick;
  logic                        expire;
  logic                        op_ok_nxt;
  logic                        reload;

  // restart the time base on every reload so each tick is a full unit
  swdt_prescaler #(
    .SEC_CYCLES  (SEC_CYCLES),
    .SEC_PER_MIN (`SWDT_SEC_PER_MIN)
  ) u_prescaler (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .clear    (reload),
    .sec_tick (sec_tick),
    .min_tick (min_tick)
  );

  assign unit_tick = (unit_cfg_r == `SWDT_UNIT_MIN) ? min_tick : sec_tick;
  assign expire    = (state_r == swdt_pkg::SWDT_ST_RUNNING) && unit_tick
                     && (count_r == 8'h01);

  // operation acceptance; anything before initialise fails
  always_comb begin
    state_nxt = state_r;
    op_ok_nxt = 1'b0;
    reload    = 1'b0;
    if (expire) begin
      state_nxt = swdt_pkg::SWDT_ST_FIRING;
    end
    if (op_valid) begin
      case (op_code)
        swdt_pkg::SWDT_OP_INIT: begin
          if (state_r != swdt_pkg::SWDT_ST_FIRING) begin
            state_nxt = swdt_pkg::SWDT_ST_STOPPED;
            op_ok_nxt = 1'b1;
          end
        end
        swdt_pkg::SWDT_OP_SET: begin
          op_ok_nxt = (state_r != swdt_pkg::SWDT_ST_UNINIT)
                      && (state_r != swdt_pkg::SWDT_ST_FIRING)
                      && (op_tick != 8'h00);
        end
        swdt_pkg::SWDT_OP_START: begin
          if (state_r == swdt_pkg::SWDT_ST_STOPPED
              || state_r == swdt_pkg::SWDT_ST_RUNNING) begin
            state_nxt = swdt_pkg::SWDT_ST_RUNNING;
            reload    = 1'b1;
            op_ok_nxt = 1'b1;
          end
        end
        swdt_pkg::SWDT_OP_KICK: begin
          // a kick in the expiry cycle still rescues the system
          if (state_r == swdt_pkg::SWDT_ST_RUNNING) begin
            state_nxt = swdt_pkg::SWDT_ST_RUNNING;
            reload    = 1'b1;
            op_ok_nxt = 1'b1;
          end
        end
        swdt_pkg::SWDT_OP_STOP: begin
          if (state_r == swdt_pkg::SWDT_ST_STOPPED
              || state_r == swdt_pkg::SWDT_ST_RUNNING) begin
            state_nxt = swdt_pkg::SWDT_ST_STOPPED;
            op_ok_nxt = 1'b1;
          end
        end
        default: begin
          op_ok_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= swdt_pkg::SWDT_ST_UNINIT;
    end else if (clk_en) begin
      if (state_r == swdt_pkg::SWDT_ST_FIRING && fire_r == 16'h0001) begin
        state_r <= swdt_pkg::SWDT_ST_UNINIT;
      end else begin
        state_r <= state_nxt;
      end
    end
  end

  // timeout configuration held across stop and start
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_cfg_r <= `SWDT_TICK_RST;
      unit_cfg_r <= `SWDT_UNIT_SEC;
    end else if (clk_en && op_valid && op_code == swdt_pkg::SWDT_OP_SET && op_ok_nxt) begin
      tick_cfg_r <= op_tick;
      unit_cfg_r <= op_unit;
    end
  end

  // countdown: loads the full count, so each reload grants tick_cfg whole units
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_r <= `SWDT_TICK_RST;
    end else if (clk_en) begin
      if (reload) begin
        count_r <= tick_cfg_r;
      end else if (state_r == swdt_pkg::SWDT_ST_RUNNING && unit_tick
                   && count_r != 8'h00) begin
        count_r <= count_r - 8'h01;
      end
    end
  end

  // system reset pulse of fixed length
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fire_r      <= 16'h0000;
      sys_reset_r <= 1'b0;
    end else if (clk_en) begin
      if (state_nxt == swdt_pkg::SWDT_ST_FIRING && state_r == swdt_pkg::SWDT_ST_RUNNING) begin
        fire_r      <= 16'(RST_CYCLES);
        sys_reset_r <= 1'b1;
      end else if (fire_r != 16'h0000) begin
        fire_r      <= fire_r - 16'h0001;
        sys_reset_r <= (fire_r != 16'h0001);
      end
    end
  end

  // answer to each operation, one cycle after it is taken
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      op_done_r <= 1'b0;
      op_ok_r   <= 1'b0;
      running_r <= 1'b0;
    end else if (clk_en) begin
      op_done_r <= op_valid;
      op_ok_r   <= op_valid && op_ok_nxt;
      running_r <= (state_nxt == swdt_pkg::SWDT_ST_RUNNING);
    end
  end

  kick_ok_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && op_valid && op_code == swdt_pkg::SWDT_OP_KICK
    && state_r == swdt_pkg::SWDT_ST_RUNNING
    |=> count_r == $past(tick_cfg_r) && op_ok_r)
    else $error("kick did not reload the count");
  zero_tick_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && op_valid && op_code == swdt_pkg::SWDT_OP_SET && op_tick == 8'h00
    |=> op_done_r && !op_ok_r && $stable(tick_cfg_r))
    else $error("zero tick count was accepted");
  start_run_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && op_valid && op_code == swdt_pkg::SWDT_OP_START
    && state_r == swdt_pkg::SWDT_ST_STOPPED
    |=> running_r && count_r == $past(tick_cfg_r))
    else $error("start did not begin the countdown");
  stop_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == swdt_pkg::SWDT_ST_STOPPED |-> !sys_reset_r && !running_r)
    else $error("stopped watchdog is running or firing");
  // init, start, kick and stop all take priority over an expiry in the same cycle
  expire_fire_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && expire && !(op_valid && op_code == swdt_pkg::SWDT_OP_KICK)
    && !(op_valid && op_code == swdt_pkg::SWDT_OP_STOP)
    && !(op_valid && op_code == swdt_pkg::SWDT_OP_INIT)
    && !(op_valid && op_code == swdt_pkg::SWDT_OP_START)
    |=> sys_reset_r)
    else $error("expiry did not raise system reset");
  // a start taken right behind the initialise may legally raise running_r
  init_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && op_valid && op_code == swdt_pkg::SWDT_OP_INIT
    && state_r != swdt_pkg::SWDT_ST_FIRING
    |=> !running_r
    ##1 (!running_r || $past(op_valid && op_code == swdt_pkg::SWDT_OP_START)))
    else $error("initialise left the watchdog running");
  op_answer_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && op_valid |=> op_done_r)
    else $error("operation got no answer");
  uninit_fail_a: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && op_valid && state_r == swdt_pkg::SWDT_ST_UNINIT
    && op_code != swdt_pkg::SWDT_OP_INIT |=> !op_ok_r)
    else $error("operation before initialise succeeded");
  unit_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
    state_r == swdt_pkg::SWDT_ST_RUNNING && unit_cfg_r == `SWDT_UNIT_MIN
    && sec_tick && !min_tick && !reload |=> $stable(count_r))
    else $error("minute unit counted a second");
endmodule : swdt_core

// >>> dv/swdt_core_tb.sv
// self-checking bench for the system watchdog core
// assumes a short second (SEC_CYC cycles) and that only this bench drives the ports
module swdt_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SEC_CYC = 10;
  localparam int unsigned RST_CYC = 4;
  logic                  sys_clk;
  logic                  rst;
  logic                  clk_en;
  logic                  op_valid;
  swdt_pkg::swdt_op_type op_code;
  logic [7:0]            op_tick;
  logic                  op_unit;
  logic                  op_done_r;
  logic                  op_ok_r;
  logic                  running_r;
  logic                  sys_reset_r;
  int                    num_errors;
  int                    total_checks;

  swdt_core #(.SEC_CYCLES(SEC_CYC), .RST_CYCLES(RST_CYC)) uut (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .op_valid(op_valid), .op_code(op_code),
    .op_tick(op_tick), .op_unit(op_unit), .op_done_r(op_done_r), .op_ok_r(op_ok_r),
    .running_r(running_r), .sys_reset_r(sys_reset_r));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  // answer is searched over a few edges; a missing answer ends the run
  task automatic do_op(input swdt_pkg::swdt_op_type code, input logic [7:0] tick,
                       input logic unit, input logic exp_ok);
    int n;
    op_valid = 1'b1;
    op_code  = code;
    op_tick  = tick;
    op_unit  = unit;
    @(negedge sys_clk);
    op_valid = 1'b0;
    n = 0;
    while (op_done_r !== 1'b1 && n < 3) begin
      @(negedge sys_clk);
      n++;
    end
    chk("op_done_r", op_done_r, 1'b1);
    if (op_done_r !== 1'b1) report_and_stop();
    chk("op_ok_r", op_ok_r, exp_ok);
    // one idle edge so the next request never re-drives op_valid in this time step
    @(negedge sys_clk);
  endtask : do_op

  task automatic wait_fire(input int lo, input int hi);
    int n;
    n = 0;
    while (sys_reset_r !== 1'b1 && n < hi) begin
      @(negedge sys_clk);
      n++;
    end
    chk("fire_in_window", {31'h0, (n >= lo && sys_reset_r === 1'b1)}, 1);
    if (sys_reset_r !== 1'b1) report_and_stop();
    chk("running_r_firing", running_r, 1'b0);
    n = 0;
    while (sys_reset_r === 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk("reset_pulse_len", n, RST_CYC);
  endtask : wait_fire

  task automatic t_before_init();
    do_op(swdt_pkg::SWDT_OP_START, 8'h00, 1'b0, 1'b0);
    do_op(swdt_pkg::SWDT_OP_SET, 8'h05, 1'b0, 1'b0);
    do_op(swdt_pkg::SWDT_OP_KICK, 8'h00, 1'b0, 1'b0);
    chk("running_r", running_r, 1'b0);
  endtask : t_before_init

  task automatic t_seconds();
    do_op(swdt_pkg::SWDT_OP_INIT, 8'h00, 1'b0, 1'b1);
    do_op(swdt_pkg::swdt_op_type'(3'h6), 8'h00, 1'b0, 1'b0);
    chk("running_r", running_r, 1'b0);
    do_op(swdt_pkg::SWDT_OP_SET, 8'h02, 1'b0, 1'b1);
    do_op(swdt_pkg::SWDT_OP_SET, 8'h00, 1'b0, 1'b0);
    do_op(swdt_pkg::SWDT_OP_START, 8'h00, 1'b0, 1'b1);
    chk("running_r", running_r, 1'b1);
    wait_fire(2 * SEC_CYC - 2, 2 * SEC_CYC + 4);
    do_op(swdt_pkg::SWDT_OP_START, 8'h00, 1'b0, 1'b0);
  endtask : t_seconds

  task automatic t_kick();
    do_op(swdt_pkg::SWDT_OP_INIT, 8'h00, 1'b0, 1'b1);
    do_op(swdt_pkg::SWDT_OP_SET, 8'hFF, 1'b0, 1'b1);
    do_op(swdt_pkg::SWDT_OP_SET, 8'h03, 1'b0, 1'b1);
    do_op(swdt_pkg::SWDT_OP_START, 8'h00, 1'b0, 1'b1);
    repeat (2 * SEC_CYC) @(negedge sys_clk);
    chk("sys_reset_r", sys_reset_r, 1'b0);
    do_op(swdt_pkg::SWDT_OP_KICK, 8'h00, 1'b0, 1'b1);
    wait_fire(3 * SEC_CYC - 2, 3 * SEC_CYC + 4);
  endtask : t_kick

  // ops are ignored while clk_en is low, so no answer may come
  task automatic t_stop();
    do_op(swdt_pkg::SWDT_OP_INIT, 8'h00, 1'b0, 1'b1);
    do_op(swdt_pkg::SWDT_OP_SET, 8'h01, 1'b0, 1'b1);
    do_op(swdt_pkg::SWDT_OP_START, 8'h00, 1'b0, 1'b1);
    clk_en   = 1'b0;
    op_valid = 1'b1;
    op_code  = swdt_pkg::SWDT_OP_STOP;
    repeat (3) @(negedge sys_clk);
    chk("op_done_r_frozen", op_done_r, 1'b0);
    // op_valid stays high into the next request; it is taken once clk_en returns
    clk_en   = 1'b1;
    do_op(swdt_pkg::SWDT_OP_STOP, 8'h00, 1'b0, 1'b1);
    chk("running_r", running_r, 1'b0);
    repeat (4 * SEC_CYC) @(negedge sys_clk);
    chk("sys_reset_r", sys_reset_r, 1'b0);
    do_op(swdt_pkg::SWDT_OP_KICK, 8'h00, 1'b0, 1'b0);
    do_op(swdt_pkg::SWDT_OP_START, 8'h00, 1'b0, 1'b1);
    wait_fire(SEC_CYC - 2, SEC_CYC + 4);
  endtask : t_stop

  task automatic t_minute_and_reset();
    do_op(swdt_pkg::SWDT_OP_INIT, 8'h00, 1'b0, 1'b1);
    do_op(swdt_pkg::SWDT_OP_SET, 8'h01, 1'b1, 1'b1);
    do_op(swdt_pkg::SWDT_OP_START, 8'h00, 1'b0, 1'b1);
    wait_fire(60 * SEC_CYC - 5, 60 * SEC_CYC + 6);
    do_op(swdt_pkg::SWDT_OP_INIT, 8'h00, 1'b0, 1'b1);
    do_op(swdt_pkg::SWDT_OP_START, 8'h00, 1'b0, 1'b1);
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    chk("running_r_after_rst", running_r, 1'b0);
    do_op(swdt_pkg::SWDT_OP_START, 8'h00, 1'b0, 1'b0);
  endtask : t_minute_and_reset

  initial begin
    num_errors   = 0;
    total_checks = 0;
    rst          = 1'b1;
    clk_en       = 1'b1;
    op_valid     = 1'b0;
    op_code      = swdt_pkg::SWDT_OP_NONE;
    op_tick      = 8'h00;
    op_unit      = 1'b0;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    t_before_init();
    t_seconds();
    t_kick();
    t_stop();
    t_minute_and_reset();
    report_and_stop();
  end
endmodule : swdt_core_tb
